// File: shared/lls_map.svh
// Offsets, field positions and reset values of the layer-1 link status register.
`ifndef LLS_MAP_SVH
`define LLS_MAP_SVH
`define LLS_ADDR_W 8
`define LLS_STATUS_OFS 8'h04
`define LLS_BIT_RFP 12
`define LLS_BIT_FREQ 11
`define LLS_BIT_LOS_HOLD 10
`define LLS_BIT_ERR_HOLD 9
`define LLS_BIT_SYNC_HOLD 8
`define LLS_BIT_LOS 2
`define LLS_BIT_ERR 1
`define LLS_BIT_SYNC 0
`define LLS_RESET 32'h00000000
`define LLS_UNMAPPED 32'h00000000
`define LLS_FRAME_PERIOD_MS 10
`endif

// File: shared/lls_pkg.sv
// Types shared by the layer-1 link status register.
package lls_pkg;
  typedef struct packed {
    logic los;
    logic code_violation;
    logic hfnsync;
  } lls_live_s;
  typedef struct packed {
    logic [7:0] address;
    logic read;
    logic write;
    logic [31:0] writedata;
  } lls_req_s;
  typedef enum logic {LLS_IDLE, LLS_ANSWER} lls_state_e;
endpackage

// File: verilog/lls_status.sv
// Read-to-clear layer-1 link status register behind an Avalon-MM slave.
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`include "lls_map.svh"

module lls_status #(
  parameter bit DEBUG_INTERFACE_OPTION = 1'b1
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Avalon-MM slave.
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Receiver status inputs, synchronous to clk_i.
  input wire logic rx_los_i,
  input wire logic rx_code_violation_i,
  input wire logic rx_hfnsync_i,
  input wire logic rx_frame_pulse_i,
  input wire logic rx_freq_mismatch_i,
  // Debug view of the mismatch pulse; tied low when the option is off.
  output logic rx_freq_alarm_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Release passes two flops so that every register leaves reset on the same edge.
  logic rst_meta_n;
  logic rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta_n <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_n <= 1'b1;
      rst_n <= rst_meta_n;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  lls_pkg::lls_req_s req;
  lls_pkg::lls_live_s live;
  lls_pkg::lls_state_e state;
  logic [31:0] status;
  logic [31:0] next_status;
  logic [31:0] events;
  // Decodes a read of the status word; it both clears the fields and selects the answer.
  function automatic logic status_read(input lls_pkg::lls_req_s r);
    return r.read && (r.address == `LLS_STATUS_OFS);
  endfunction
  wire accept = (state == lls_pkg::LLS_IDLE) && (req.read || req.write);
  // A read of the status word is the only clearing event.
  wire clear_rd = accept && status_read(req);

  assign req = '{address: avs_address_i, read: avs_read_i, write: avs_write_i, writedata: avs_writedata_i};
  assign live = '{los: rx_los_i, code_violation: rx_code_violation_i, hfnsync: rx_hfnsync_i};

  // Live and sticky fields share one set path, since all of them are read-to-clear.
  always_comb begin
    events = `LLS_RESET;
    events[`LLS_BIT_RFP] = rx_frame_pulse_i;
    events[`LLS_BIT_FREQ] = rx_freq_mismatch_i;
    events[`LLS_BIT_LOS_HOLD] = live.los;
    events[`LLS_BIT_ERR_HOLD] = live.code_violation;
    events[`LLS_BIT_SYNC_HOLD] = live.hfnsync;
    events[`LLS_BIT_LOS] = live.los;
    events[`LLS_BIT_ERR] = live.code_violation;
    events[`LLS_BIT_SYNC] = live.hfnsync;
  end

  // read clears, set wins
  // Clearing on the read lets a condition still present show again on the next read, which is why
  // software must read twice to see the present state rather than history.
  assign next_status = (clear_rd ? `LLS_RESET : status) | events;

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      status <= `LLS_RESET;
    end else begin
      status <= next_status;
    end
  end

  // Checks on the status fields.
  read_reload_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    clear_rd |=> status == $past(events))
    else $error("Read did not reload the fields.");
  sticky_keep_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !clear_rd |=> (status & $past(status)) == $past(status))
    else $error("Sticky field dropped without a read.");
  write_ignore_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept && req.write |=> (status & $past(status)) == $past(status))
    else $error("Write changed a field.");
  status_reserved_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    status[31:13] == 19'h0 && status[7:3] == 5'h0)
    else $error("Reserved status bit set.");
  reset_zero_a: assert property (@(posedge clk_i)
    $rose(rst_n) |-> status == `LLS_RESET && avs_waitrequest_o && !rx_freq_alarm_o)
    else $error("Fields not zero after reset.");
  frame_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    clear_rd && !rx_frame_pulse_i |=> !status[`LLS_BIT_RFP])
    else $error("Frame bit not cleared by read.");
  freq_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    clear_rd && !rx_freq_mismatch_i |=> !status[`LLS_BIT_FREQ])
    else $error("Mismatch bit not cleared by read.");
  los_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    clear_rd && !rx_los_i |=> !status[`LLS_BIT_LOS] && !status[`LLS_BIT_LOS_HOLD])
    else $error("Loss bits not cleared by read.");
  err_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    clear_rd && !rx_code_violation_i |=> !status[`LLS_BIT_ERR] && !status[`LLS_BIT_ERR_HOLD])
    else $error("Error bits not cleared by read.");
  sync_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    clear_rd && !rx_hfnsync_i |=> !status[`LLS_BIT_SYNC] && !status[`LLS_BIT_SYNC_HOLD])
    else $error("Sync bits not cleared by read.");

  ////////////////////////////////////////////////////////////////////////////
  // One wait state: the request is taken on the first edge and answered on the next.
  // Writes are answered the same way so that a master never stalls, but they change no field.
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state <= lls_pkg::LLS_IDLE;
      avs_waitrequest_o <= 1'b1;
      avs_readdata_o <= `LLS_UNMAPPED;
    end else begin
      unique case (state)
        lls_pkg::LLS_IDLE: begin
          if (accept) begin
            state <= lls_pkg::LLS_ANSWER;
            avs_waitrequest_o <= 1'b0;
            avs_readdata_o <= status_read(req) ? status : `LLS_UNMAPPED;
          end
        end
        lls_pkg::LLS_ANSWER: begin
          state <= lls_pkg::LLS_IDLE;
          avs_waitrequest_o <= 1'b1;
        end
      endcase
    end
  end

  // Checks on the bus answer.
  read_data_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept && status_read(req) |=> avs_readdata_o == $past(status))
    else $error("Read answer not the held fields.");
  unmapped_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept && !status_read(req) |=> avs_readdata_o == `LLS_UNMAPPED)
    else $error("Other access answered non-zero.");
  answer_once_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("Answer stood too long.");
  idle_wait_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !avs_waitrequest_o |-> state == lls_pkg::LLS_ANSWER)
    else $error("Answer given outside the answer state.");

  ////////////////////////////////////////////////////////////////////////////
  // With the option off the pin stays tied low, so that both builds share one port list.
  // debug mismatch output
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rx_freq_alarm_o <= 1'b0;
    end else begin
      rx_freq_alarm_o <= DEBUG_INTERFACE_OPTION & rx_freq_mismatch_i;
    end
  end

  debug_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !rx_freq_mismatch_i |=> !rx_freq_alarm_o)
    else $error("Debug pulse without mismatch.");

  ////////////////////////////////////////////////////////////////////////////
  frame_sticky_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rx_frame_pulse_i |=> status[`LLS_BIT_RFP]) else $error("Frame pulse not held.");
  freq_sticky_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    status[`LLS_BIT_FREQ] && !clear_rd |=> status[`LLS_BIT_FREQ]) else $error("Mismatch bit lost.");
  debug_pulse_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rx_freq_mismatch_i |=> rx_freq_alarm_o == DEBUG_INTERFACE_OPTION) else $error("Debug pulse wrong.");
  hold_copy_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    live.los |=> status[`LLS_BIT_LOS_HOLD]) else $error("Hold copy missing.");
  hold_err_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    live.code_violation |=> status[`LLS_BIT_ERR_HOLD])
    else $error("Error hold copy missing.");
  hold_sync_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    live.hfnsync |=> status[`LLS_BIT_SYNC_HOLD])
    else $error("Sync hold copy missing.");
  los_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rx_los_i |=> status[`LLS_BIT_LOS]) else $error("Loss flag missing.");
  err_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rx_code_violation_i |=> status[`LLS_BIT_ERR]) else $error("Error flag missing.");
  sync_flag_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rx_hfnsync_i |=> status[`LLS_BIT_SYNC]) else $error("Sync flag missing.");
  read_clear_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    clear_rd && events == `LLS_RESET |=> status == `LLS_RESET ##1 avs_readdata_o == $past(avs_readdata_o))
    else $error("Read did not clear.");
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    !avs_waitrequest_o |-> avs_readdata_o[31:13] == 19'h0 && avs_readdata_o[7:3] == 5'h0)
    else $error("Reserved bits set.");
  answer_time_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    accept |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("Answer timing wrong.");

endmodule

// File: testbench/link_layer1_status_reg_bench.sv
// Self-checking bench for the layer-1 link status register.
`timescale 1ns/1ps
`include "lls_map.svh"
module link_layer1_status_reg_bench;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic rx_freq_alarm_o;
  lls_pkg::lls_live_s live = '0;
  logic rfp = 1'b0;
  logic mis = 1'b0;
  logic last_mis = 1'b0;
  logic stim_on = 1'b0;
  logic [31:0] acc = 32'h00000000;
  logic [31:0] exp_q[$];
  int miscompares = 0;
  int checks_done = 0;
  int cycles = 0;
  wire logic [31:0] ev = {19'h00000, rfp, mis, live, 5'h00, live};
  wire logic taken = (avs_read_i | avs_write_i) & (avs_waitrequest_o === 1'b1);

  always #50 clk_i = ~clk_i;

  lls_status #(.DEBUG_INTERFACE_OPTION(1'b1)) u_dut (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o), .rx_los_i(live.los),
    .rx_code_violation_i(live.code_violation), .rx_hfnsync_i(live.hfnsync),
    .rx_frame_pulse_i(rfp), .rx_freq_mismatch_i(mis), .rx_freq_alarm_o(rx_freq_alarm_o));

  task automatic end_sim;
    $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] e, input logic [31:0] s);
    checks_done++;
    if (s !== e) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, e, s);
    end
  endtask

  task automatic bus(input logic wr, input logic [7:0] a);
    @(posedge clk_i);
    avs_read_i <= !wr;
    avs_write_i <= wr;
    avs_address_i <= a;
    avs_writedata_i <= $urandom;
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  // Random events; a pulse may repeat, which the sticky bits must absorb.
  always @(posedge clk_i) begin
    live <= stim_on ? 3'($urandom_range(7)) : 3'h0;
    rfp <= stim_on && $urandom_range(3) == 0;
    mis <= stim_on && $urandom_range(3) == 0;
    last_mis <= mis;
    cycles <= cycles + 1;
    if (cycles > 3000) begin
      miscompares++;
      end_sim();
    end
  end

  always @(posedge clk_i) begin
    if (taken && avs_read_i) exp_q.push_back(avs_address_i == `LLS_STATUS_OFS ? acc : `LLS_UNMAPPED);
    acc <= ((taken && avs_read_i && avs_address_i == `LLS_STATUS_OFS) ? 32'h00000000 : acc) | ev;
  end

  // Watches the answers and the debug alarm output.
  always @(posedge clk_i) begin
    if (avs_waitrequest_o === 1'b0 && avs_read_i) begin
      if (exp_q.size() == 0) cmp("answer without request", 32'h0, 32'h1);
      else cmp("readdata", exp_q.pop_front(), avs_readdata_o);
    end
    if (stim_on) cmp("rx_freq_alarm_o", {31'h0, last_mis}, {31'h0, rx_freq_alarm_o});
  end

  initial begin
    void'($urandom(30581));
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    stim_on <= 1'b1;
    for (int i = 0; i < 80; i++) begin
      bus($urandom_range(3) == 0, $urandom_range(2) == 0 ? 8'($urandom) : `LLS_STATUS_OFS);
    end
    stim_on <= 1'b0;
    bus(1'b0, `LLS_STATUS_OFS);
    bus(1'b0, `LLS_STATUS_OFS);
    repeat (3) @(posedge clk_i);
    end_sim();
  end
endmodule
